// file: core/sar_adc_sequencer.sv
// Sequencer for a 10-bit converter with sixteen inputs in four groups.
// Assumes an APB master, an analog mux, sample-hold and comparator outside.
//
// What this block does
// R1 - Resolve each sample by binary search into a ten-bit code.
// R2 - Software clears go before changing mode or channel.
// R3 - One write may set go and change mode or channel together.
// R4 - Single mode: one start gives exactly one conversion of one channel.
// R5 - Single result lands in the converted channel's result register.
// R6 - Single completion sets done flag; interrupt if enabled.
// R7 - Single mode: go reads one while busy, then clears and idles.
// R8 - Scan starts at the lowest channel of the chosen group.
// R9 - Scan stores each channel's result as soon as it finishes.
// R10 - After the last selected channel: set done flag, interrupt if enabled, restart group.
// R11 - Scan repeats while go stays one; stops when cleared.
// R12 - Start delay of six states slow or four states fast before sampling.
// R13 - Sampling lasts 31 states slow or 15 states fast.
// R14 - First conversion takes 131 states slow or 69 states fast.
// R15 - Later scan conversions take 128 states slow or 66 fast.
// R16 - Enabled trigger falling edge sets go; ignored when disabled.
// R17 - Triggered conversions run exactly like software-started ones.
// R18 - Channel msb joins the three low select bits.
// R19 - Result sits in bits 15 to 6; low six bits read zero.
// R20 - Upper byte read latches lower byte for a later read.
// R21 - Done flag clears only by writing zero after reading it as one.
// R22 - Scan: two low select bits give channel count minus one.
// R23 - Drive mux, sample-hold and comparator steps; reset returns to idle.
//
// Chosen here: register access over APB and the register addresses.
`default_nettype none
module sar_adc_sequencer
	import sar_adc_pkg::*;
#(
	parameter int RES_W = 10
) (
	input wire logic clock,
	input wire logic reset,
	input wire logic [7:0] paddr,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic ext_trigger_pin,
	input wire logic comp_above,
	output logic [3:0] mux_select,
	output logic sample_hold,
	output logic [RES_W-1:0] dac_code,
	output logic conversion_done_irq
);
	if (RES_W != 10) begin : g_chk
		$error("result layout serves RES_W of 10 only");
	end

	// ****************
	// Registers
	// ****************
	seq_state_e st_ff;
	logic [7:0] cnt_ff;
	logic [3:0] step_cnt_ff;
	logic done_ff, ie_ff, go_ff, scan_ff, speed_ff;
	logic [2:0] ch_ff;
	logic trig_en_ff, ch_msb_ff;
	logic [1:0] ctl_rsv_ff;
	logic seen_ff, trig_prev_ff;
	logic scan_q_ff, speed_q_ff;
	logic [1:0] last_q_ff;
	logic [3:0] cur_ch_ff;
	logic sh_ff, irq_ff;
	logic [RES_W-1:0] result_ff [4];
	logic [7:0] temp_ff;
	logic [31:0] prdata_ff;
	logic pready_ff, pslverr_ff;
	logic nxt_done, nxt_ie;
	logic eng_init, eng_step, eng_busy;
	logic [RES_W-1:0] eng_code;

	// ****************
	// APB decode
	// ****************
	logic acc, xfer, wr_cs, wr_ctl, rd_cs, mapped;
	logic [1:0] ridx;
	assign acc = psel & penable;
	assign xfer = acc & pready_ff;
	assign wr_cs = xfer & pwrite & (paddr == OFS_CTRL_STATUS);
	assign wr_ctl = xfer & pwrite & (paddr == OFS_CONTROL);
	assign rd_cs = xfer & ~pwrite & (paddr == OFS_CTRL_STATUS);
	assign ridx = paddr[3:2];
	assign mapped = (paddr == OFS_CTRL_STATUS) || (paddr == OFS_CONTROL)
		|| (paddr == OFS_RESULT_LO)
		|| ({paddr[7:4], paddr[1:0]} == {OFS_RESULT_WORD[7:4], 2'b00})
		|| ({paddr[7:4], paddr[1:0]} == {OFS_RESULT_HI[7:4], 2'b00});

	logic [7:0] cs_view, ctl_view;
	assign cs_view = {done_ff, ie_ff, go_ff, scan_ff, speed_ff, ch_ff};
	assign ctl_view = CONTROL_ONES | {trig_en_ff, 3'b000, ctl_rsv_ff, 1'b0, ch_msb_ff};

	logic [31:0] rd_mux;
	always_comb begin
		rd_mux = 32'h0000_0000;
		if (paddr == OFS_CTRL_STATUS) begin
			rd_mux[7:0] = cs_view;
		end else if (paddr == OFS_CONTROL) begin
			rd_mux[7:0] = ctl_view;
		end else if (paddr == OFS_RESULT_LO) begin
			rd_mux[7:0] = temp_ff;
		end else if (paddr[7:4] == OFS_RESULT_WORD[7:4]) begin
			rd_mux[15:0] = {result_ff[ridx], {RESULT_LSB{1'b0}}}; // [R19]
		end else if (paddr[7:4] == OFS_RESULT_HI[7:4]) begin
			rd_mux[7:0] = result_ff[ridx][RES_W-1:RES_W-8];
		end
	end

	// One wait state: data and error are ready from a flop
	always_ff @(posedge clock) begin
		if (reset) begin
			pready_ff <= 1'b0;
			pslverr_ff <= 1'b0;
			prdata_ff <= 32'h0000_0000;
		end else begin
			pready_ff <= acc & ~pready_ff;
			if (acc & ~pready_ff) begin
				pslverr_ff <= ~mapped;
				prdata_ff <= pwrite ? 32'h0000_0000 : rd_mux;
			end
		end
	end

	// Upper byte read latches the lower byte
	always_ff @(posedge clock) begin
		if (reset) begin
			temp_ff <= 8'h00;
		end else if (xfer & ~pwrite & (paddr[7:4] == OFS_RESULT_HI[7:4])
			& (paddr[1:0] == 2'b00)) begin
			temp_ff <= {result_ff[ridx][1:0], {RESULT_LSB{1'b0}}}; // [R20]
		end
	end

	// ****************
	// Control bits
	// ****************
	logic trig_edge, seq_done, single_done;
	assign trig_edge = trig_en_ff & trig_prev_ff & ~ext_trigger_pin; // [R16]

	always_ff @(posedge clock) begin
		if (reset) begin
			trig_prev_ff <= 1'b1;
		end else begin
			trig_prev_ff <= ext_trigger_pin;
		end
	end

	always_ff @(posedge clock) begin
		if (reset) begin
			{ie_ff, scan_ff, speed_ff, ch_ff} <= {CTRL_RESET[BIT_IRQ_EN], CTRL_RESET[BIT_SCAN:0]};
			{trig_en_ff, ctl_rsv_ff, ch_msb_ff} <= 4'h0;
		end else begin
			if (wr_cs) begin
				ie_ff <= pwdata[BIT_IRQ_EN];
				scan_ff <= pwdata[BIT_SCAN];
				speed_ff <= pwdata[BIT_SPEED];
				ch_ff <= pwdata[2:0];
			end
			if (wr_ctl) begin
				trig_en_ff <= pwdata[BIT_TRIG_EN];
				ctl_rsv_ff <= pwdata[3:2];
				ch_msb_ff <= pwdata[BIT_CH_MSB];
			end
		end
	end

	// Trigger sets go like software does; single completion clears it
	always_ff @(posedge clock) begin
		if (reset) begin
			go_ff <= 1'b0;
		end else if (trig_edge) begin
			go_ff <= 1'b1; // [R16] [R17]
		end else if (wr_cs) begin
			go_ff <= pwdata[BIT_GO];
		end else if (single_done) begin
			go_ff <= 1'b0; // [R7]
		end
	end

	// Set wins over clear; clear needs a prior read as one
	always_comb begin
		nxt_done = done_ff;
		if (wr_cs & ~pwdata[BIT_DONE] & seen_ff) begin
			nxt_done = 1'b0; // [R21]
		end
		if (seq_done) begin
			nxt_done = 1'b1; // [R6] [R10]
		end
		nxt_ie = wr_cs ? pwdata[BIT_IRQ_EN] : ie_ff;
	end

	always_ff @(posedge clock) begin
		if (reset) begin
			done_ff <= 1'b0;
			seen_ff <= 1'b0;
			irq_ff <= 1'b0;
		end else begin
			done_ff <= nxt_done;
			irq_ff <= nxt_done & nxt_ie; // [R6] [R10]
			if (~nxt_done) begin
				seen_ff <= 1'b0;
			end else if (rd_cs & prdata_ff[BIT_DONE]) begin
				seen_ff <= 1'b1; // [R21]
			end
		end
	end

	// ****************
	// Sequencer
	// ****************
	logic [7:0] td_len, spl_len, apx_len, rsc_len;
	assign td_len = speed_q_ff ? 8'(TD_FAST) : 8'(TD_SLOW);
	assign spl_len = speed_q_ff ? 8'(TSPL_FAST) : 8'(TSPL_SLOW);
	assign apx_len = speed_q_ff ? 8'(APPROX_FAST) : 8'(APPROX_SLOW);
	assign rsc_len = speed_q_ff ? 8'(RESCAN_FAST) : 8'(RESCAN_SLOW);
	logic [3:0] step_len;
	assign step_len = speed_q_ff ? 4'((APPROX_FAST - 1) / RES_W)
		: 4'((APPROX_SLOW - 1) / RES_W);

	logic last_ch;
	assign last_ch = (cur_ch_ff[1:0] == last_q_ff);
	assign single_done = (st_ff == ST_STORE) & ~scan_q_ff & go_ff;
	assign seq_done = (st_ff == ST_STORE) & go_ff & (~scan_q_ff | last_ch);
	assign eng_init = (st_ff == ST_SAMPLE) & (cnt_ff == 8'h00) & go_ff;
	assign eng_step = (st_ff == ST_APPROX) & (step_cnt_ff == 4'h0) & eng_busy;

	always_ff @(posedge clock) begin
		if (reset) begin
			st_ff <= ST_IDLE; // [R23]
			cnt_ff <= 8'h00;
			cur_ch_ff <= 4'h0;
			scan_q_ff <= 1'b0;
			speed_q_ff <= 1'b0;
			last_q_ff <= 2'b00;
		end else if (st_ff != ST_IDLE && !go_ff) begin
			st_ff <= ST_IDLE; // [R11]
		end else begin
			cnt_ff <= cnt_ff - 8'h01;
			unique case (st_ff)
				ST_IDLE: begin
					if (go_ff) begin
						// Settings are taken as they stand when go rises [R3]
						scan_q_ff <= scan_ff;
						speed_q_ff <= speed_ff;
						last_q_ff <= scan_ff ? ch_ff[1:0] : 2'b00; // [R22]
						cur_ch_ff <= scan_ff ? {ch_msb_ff, ch_ff[2], 2'b00} // [R8]
							: {ch_msb_ff, ch_ff}; // [R4] [R18]
						cnt_ff <= (speed_ff ? 8'(TD_FAST) : 8'(TD_SLOW)) - 8'h01; // [R12]
						st_ff <= ST_DELAY;
					end
				end
				ST_DELAY: begin
					if (cnt_ff == 8'h00) begin
						cnt_ff <= spl_len - 8'h01; // [R13]
						st_ff <= ST_SAMPLE;
					end
				end
				ST_SAMPLE: begin
					if (cnt_ff == 8'h00) begin
						cnt_ff <= apx_len - 8'h02; // [R14]
						st_ff <= ST_APPROX;
					end
				end
				ST_APPROX: begin
					if (cnt_ff == 8'h00) begin
						st_ff <= ST_STORE;
					end
				end
				ST_STORE: begin
					if (scan_q_ff) begin
						// Next channel or back to the group's first [R9] [R10]
						cur_ch_ff[1:0] <= last_ch ? 2'b00 : cur_ch_ff[1:0] + 2'b01;
						cnt_ff <= rsc_len - 8'h01; // [R15]
						st_ff <= ST_DELAY;
					end else begin
						st_ff <= ST_IDLE; // [R4] [R7]
					end
				end
			endcase
		end
	end

	// Step pacing within the approximation phase
	always_ff @(posedge clock) begin
		if (reset) begin
			step_cnt_ff <= 4'h0;
		end else if (eng_init || eng_step) begin
			step_cnt_ff <= step_len - 4'h1;
		end else if (st_ff == ST_APPROX) begin
			step_cnt_ff <= step_cnt_ff - 4'h1;
		end
	end

	always_ff @(posedge clock) begin
		if (reset) begin
			sh_ff <= 1'b0;
		end else begin
			sh_ff <= go_ff && ((st_ff == ST_DELAY && cnt_ff == 8'h00)
				|| (st_ff == ST_SAMPLE && cnt_ff != 8'h00)); // [R13] [R23]
		end
	end

	// Result store per channel
	for (genvar i = 0; i < 4; i++) begin : g_res
		always_ff @(posedge clock) begin
			if (reset) begin
				result_ff[i] <= '0;
			end else if (st_ff == ST_STORE && go_ff && cur_ch_ff[1:0] == 2'(i)) begin
				result_ff[i] <= eng_code; // [R5] [R9]
			end
		end
	end

	sar_step_engine #(.RES_W(RES_W)) u_engine (
		.clock(clock),
		.reset(reset),
		.init(eng_init),
		.step(eng_step),
		.comp_above(comp_above),
		.trial_code(eng_code),
		.busy(eng_busy)
	);

	assign prdata = prdata_ff;
	assign pready = pready_ff;
	assign pslverr = pslverr_ff;
	assign mux_select = cur_ch_ff;
	assign sample_hold = sh_ff;
	assign dac_code = eng_code;
	assign conversion_done_irq = irq_ff;

	// ****************
	// Assertions
	// ****************
	default clocking cb @(posedge clock); endclocking
	default disable iff (reset);

	a_go_single_clear: assert property (single_done && !wr_cs && !trig_edge |=> !go_ff) // [R7]
		else $error("single conversion left go set");
	a_irq_level: assert property (conversion_done_irq == (done_ff && ie_ff)) // [R6]
		else $error("interrupt does not follow flag and enable");
	a_done_set: assert property (seq_done |=> done_ff) // [R10]
		else $error("done flag not set at completion");
	a_flag_clear: assert property ($fell(done_ff) |-> $past(seen_ff)) // [R21]
		else $error("done flag cleared without prior read");
	a_sample_slow: assert property ($fell(sh_ff) && !speed_q_ff && go_ff
		|-> $past(sh_ff, 31) && !$past(sh_ff, 32)) // [R13]
		else $error("slow sampling not 31 states");
	a_sample_fast: assert property ($fell(sh_ff) && speed_q_ff && go_ff
		|-> $past(sh_ff, 15) && !$past(sh_ff, 16)) // [R13]
		else $error("fast sampling not 15 states");
	a_start_slow: assert property (st_ff == ST_IDLE && go_ff && !speed_ff
		|-> ##7 (sh_ff || !go_ff || !$past(go_ff))) // [R12]
		else $error("slow start delay wrong");
	a_scan_first: assert property (st_ff == ST_IDLE && go_ff && scan_ff
		|=> cur_ch_ff == {$past(ch_msb_ff), $past(ch_ff[2]), 2'b00}) // [R8]
		else $error("scan did not start at group base");
	a_store_result: assert property (st_ff == ST_STORE && go_ff
		|=> result_ff[$past(cur_ch_ff[1:0])] == $past(eng_code)) // [R5]
		else $error("result not stored to channel register");
	a_scan_keep: assert property (st_ff == ST_STORE && scan_q_ff && go_ff && !wr_cs
		|=> go_ff && st_ff == ST_DELAY) // [R11]
		else $error("scan stopped on its own");
	a_trig_off: assert property (!trig_en_ff && !go_ff && !wr_cs |=> !go_ff) // [R16]
		else $error("go set without enabled trigger");

	c_single: cover property (single_done);
	c_scan_wrap: cover property (st_ff == ST_STORE && scan_q_ff && last_ch && go_ff);
	c_trigger: cover property (trig_edge && !go_ff);
	c_irq: cover property ($rose(conversion_done_irq));
endmodule : sar_adc_sequencer
`default_nettype wire

// file: core/sar_adc_pkg.sv
// Constants, register map and types for the converter sequencer.
// Assumes a 32-bit APB master and one state per clock cycle.
`default_nettype none
package sar_adc_pkg;
	// ****************
	// Register map
	// ****************
	localparam logic [7:0] OFS_CTRL_STATUS = 8'h00;
	localparam logic [7:0] OFS_CONTROL = 8'h04;
	localparam logic [7:0] OFS_RESULT_WORD = 8'h10;
	localparam logic [7:0] OFS_RESULT_HI = 8'h20;
	localparam logic [7:0] OFS_RESULT_LO = 8'h30;
	localparam int BIT_DONE = 7;
	localparam int BIT_IRQ_EN = 6;
	localparam int BIT_GO = 5;
	localparam int BIT_SCAN = 4;
	localparam int BIT_SPEED = 3;
	localparam int BIT_TRIG_EN = 7;
	localparam int BIT_CH_MSB = 0;
	localparam logic [7:0] CONTROL_ONES = 8'h72;
	localparam logic [7:0] CTRL_RESET = 8'h00;
	localparam int RESULT_LSB = 6;
	// ****************
	// Timing in states
	// ****************
	localparam int TD_SLOW = 6;
	localparam int TD_FAST = 4;
	localparam int TSPL_SLOW = 31;
	localparam int TSPL_FAST = 15;
	localparam int TCONV_SLOW = 131;
	localparam int TCONV_FAST = 69;
	localparam int TSCAN_SLOW = 128;
	localparam int TSCAN_FAST = 66;
	localparam int APPROX_SLOW = TCONV_SLOW - TD_SLOW - TSPL_SLOW;
	localparam int APPROX_FAST = TCONV_FAST - TD_FAST - TSPL_FAST;
	localparam int RESCAN_SLOW = TSCAN_SLOW - TSPL_SLOW - APPROX_SLOW;
	localparam int RESCAN_FAST = TSCAN_FAST - TSPL_FAST - APPROX_FAST;
	typedef enum logic [2:0] {ST_IDLE, ST_DELAY, ST_SAMPLE, ST_APPROX, ST_STORE} seq_state_e;
endpackage : sar_adc_pkg
`default_nettype wire

// file: core/sar_step_engine.sv
// Successive-approximation register: one trial bit resolved per step.
// Assumes comp_above is high when the held input lies above dac_code.
`default_nettype none
module sar_step_engine #(
	parameter int RES_W = 10
) (
	input wire logic clock,
	input wire logic reset,
	input wire logic init,
	input wire logic step,
	input wire logic comp_above,
	output logic [RES_W-1:0] trial_code,
	output logic busy
);
	logic [RES_W-1:0] trial_ff;
	logic [RES_W-1:0] ptr_ff;

	if (RES_W < 2) begin : g_chk
		$error("RES_W must be at least 2");
	end

	// ****************
	// Binary search
	// ****************
	always_ff @(posedge clock) begin
		if (reset) begin
			trial_ff <= '0;
			ptr_ff <= '0;
		end else if (init) begin
			trial_ff <= {1'b1, {(RES_W-1){1'b0}}};
			ptr_ff <= {1'b1, {(RES_W-1){1'b0}}};
		end else if (step && ptr_ff != '0) begin
			// Keep or drop the trial bit, then try the next one [R1]
			trial_ff <= (comp_above ? trial_ff : (trial_ff & ~ptr_ff)) | (ptr_ff >> 1);
			ptr_ff <= ptr_ff >> 1;
		end
	end

	assign trial_code = trial_ff;
	assign busy = (ptr_ff != '0);
endmodule : sar_step_engine
`default_nettype wire

// file: bench/analog_front_model.sv
// Front-end model: analog mux, sample-hold and comparator.
// Assumes each level sits half an LSB above its code, so a tie counts as above.
`default_nettype none
module analog_front_model (
	input wire logic clock,
	input wire logic [3:0] mux_select,
	input wire logic sample_hold,
	input wire logic [9:0] dac_code,
	input wire logic [9:0] level [16],
	output logic comp_above
);
	timeunit 1ns;
	timeprecision 1ps;
	// ****
	// Track while sampling, hold after
	// ****
	logic [9:0] held_ff = 10'h000;
	always @(posedge clock) begin
		if (sample_hold) begin
			held_ff <= level[mux_select];
		end
	end
	assign comp_above = (held_ff >= dac_code);
endmodule : analog_front_model
`default_nettype wire

// file: bench/testbench.sv
// Testbench: APB master, stimulus and reference model of the sequencer.
// Assumes the front-end model answers the comparator from per-channel levels.
`default_nettype none
module testbench import sar_adc_pkg::*;;
	timeunit 1ns;
	timeprecision 1ps;
	// ****
	// Signals and instances
	// ****
	logic clock = 1'b0;
	logic reset = 1'b1;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic trig = 1'b1;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h00000000;
	logic [31:0] prdata;
	logic [31:0] rd;
	logic pready, pslverr, sh, irq, cmp, er;
	logic [3:0] mux;
	logic [9:0] dac;
	logic [9:0] lvl [16];
	logic [3:0] muxq [$];
	int gapq [$];
	int res_m [4];
	int error_cnt = 0;
	int checked = 0;
	int spl = 0;
	int hl = 0;
	int gap = 0;
	int n;
	integer seed = 32'h5031706A;
	always #4 clock = ~clock;
	sar_adc_sequencer i_dut (.clock(clock), .reset(reset), .paddr(paddr), .psel(psel),
		.penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .ext_trigger_pin(trig), .comp_above(cmp),
		.mux_select(mux), .sample_hold(sh), .dac_code(dac), .conversion_done_irq(irq));
	analog_front_model i_afe (.clock(clock), .mux_select(mux), .sample_hold(sh),
		.dac_code(dac), .level(lvl), .comp_above(cmp));
	// ****
	// Monitor and tasks
	// ****
	always @(negedge clock) begin
		gap++;
		if (sh === 1'b1) begin
			hl++;
			if (hl == 1) begin
				muxq.push_back(mux);
				gapq.push_back(gap);
				gap = 0;
			end
		end else if (hl > 0) begin
			check("sample length", hl, spl);
			hl = 0;
		end
	end
	task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		checked++;
		if (seen !== exp) begin
			error_cnt++;
			$display("unexpected %s expected %h seen %h", nm, exp, seen);
		end
	endtask : check
	task automatic stop_test;
		$display("errors %0d checks %0d", error_cnt, checked);
		if (error_cnt == 0 && checked > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask : stop_test
	task automatic wait_for(ref logic s, input logic v, output int c);
		c = 0;
		do begin
			@(negedge clock);
			c++;
		end while (s !== v && c < 2000);
		if (s !== v) begin
			error_cnt++;
			stop_test();
		end
	endtask : wait_for
	task automatic apb(input logic [7:0] a, input logic w, input logic [7:0] d);
		int c;
		@(posedge clock);
		psel <= 1'b1;
		penable <= 1'b0;
		paddr <= a;
		pwrite <= w;
		pwdata <= {24'h000000, d};
		@(posedge clock);
		penable <= 1'b1;
		c = 0;
		do begin
			@(posedge clock);
			c++;
		end while (pready !== 1'b1 && c < 50);
		if (pready !== 1'b1) begin
			error_cnt++;
			stop_test();
		end
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb
	task automatic pulse;
		@(posedge clock);
		trig <= 1'b0;
		repeat (3) @(posedge clock);
		trig <= 1'b1;
	endtask : pulse
	// ****
	// Main sequence
	// ****
	initial begin
		for (int i = 0; i < 16; i++) begin
			lvl[i] = 10'($random(seed));
		end
		repeat (5) @(posedge clock);
		reset <= 1'b0;
		apb(OFS_CTRL_STATUS, 1'b0, 8'h00);
		check("status reset", rd[7:0], CTRL_RESET);
		apb(OFS_CONTROL, 1'b0, 8'h00);
		check("control reset", rd[7:0], CONTROL_ONES);
		apb(8'hFC, 1'b0, 8'h00);
		check("unmapped error", er, 1'b1);
		for (int k = 0; k < 2; k++) begin
			logic [3:0] ch;
			logic [7:0] sb;
			ch = 4'($random(seed));
			sb = {4'b0100, k[0], ch[2:0]};
			spl = k ? TSPL_FAST : TSPL_SLOW;
			muxq.delete();
			gapq.delete();
			apb(OFS_CONTROL, 1'b1, {k[0], 6'h00, ch[3]});
			apb(OFS_CONTROL, 1'b0, 8'h00);
			check("control", rd[7:0], CONTROL_ONES | {k[0], 6'h00, ch[3]});
			if (k == 0) begin
				apb(OFS_CTRL_STATUS, 1'b1, sb | 8'h20);
				gap = 0;
				wait_for(irq, 1'b1, n);
				check("conversion time", n > TCONV_SLOW && n <= TCONV_SLOW + 5, 1'b1);
				check("start delay", gapq[0] > TD_SLOW && gapq[0] <= 10, 1'b1);
			end else begin
				apb(OFS_CTRL_STATUS, 1'b1, sb);
				pulse();
				apb(OFS_CTRL_STATUS, 1'b0, 8'h00);
				check("go by trigger", rd[5], 1'b1);
				wait_for(irq, 1'b1, n);
			end
			res_m[ch[1:0]] = lvl[ch];
			check("one sample", muxq.size(), 1);
			check("mux channel", muxq[0], ch);
			apb(OFS_CTRL_STATUS, 1'b1, sb);
			apb(OFS_CTRL_STATUS, 1'b0, 8'h00);
			check("done kept", rd[7:0], sb | 8'h80);
			check("irq", irq, 1'b1);
			apb(OFS_CTRL_STATUS, 1'b1, sb);
			apb(OFS_CTRL_STATUS, 1'b0, 8'h00);
			check("done cleared", rd[7:0], sb);
			check("irq off", irq, 1'b0);
			apb(OFS_RESULT_WORD | {4'h0, ch[1:0], 2'b00}, 1'b0, 8'h00);
			check("result word", rd[15:0], {res_m[ch[1:0]][9:0], 6'h00});
			apb(OFS_RESULT_HI | {4'h0, ch[1:0], 2'b00}, 1'b0, 8'h00);
			check("result high", rd[7:0], res_m[ch[1:0]][9:2]);
			apb(OFS_RESULT_LO, 1'b0, 8'h00);
			check("result low", rd[7:0], {res_m[ch[1:0]][1:0], 6'h00});
		end
		muxq.delete();
		apb(OFS_CONTROL, 1'b1, 8'h00);
		pulse();
		repeat (100) @(posedge clock);
		check("ignored trigger", muxq.size(), 0);
		spl = TSPL_SLOW;
		apb(OFS_CTRL_STATUS, 1'b1, 8'h20);
		repeat (60) @(posedge clock);
		reset <= 1'b1;
		repeat (5) @(posedge clock);
		reset <= 1'b0;
		muxq.delete();
		apb(OFS_CTRL_STATUS, 1'b0, 8'h00);
		check("reset idle", rd[7:0], CTRL_RESET);
		check("reset mux", mux, 4'h0);
		repeat (150) @(posedge clock);
		check("reset stops", muxq.size(), 0);
		for (int k = 0; k < 4; k++) begin
			logic [3:0] ch;
			int cnt;
			ch = {k[1:0], 2'($random(seed))};
			cnt = ch[1:0] + 1;
			spl = k[0] ? TSPL_FAST : TSPL_SLOW;
			muxq.delete();
			gapq.delete();
			apb(OFS_CONTROL, 1'b1, {7'h00, ch[3]});
			apb(OFS_CTRL_STATUS, 1'b1, {4'b0111, k[0], ch[2:0]});
			wait_for(irq, 1'b1, n);
			repeat (20) @(posedge clock);
			for (int i = 0; i <= cnt; i++) begin
				check("scan channel", muxq[i], {ch[3:2], 2'(i % cnt)});
				if (i > 0) begin
					check("scan period", gapq[i], k[0] ? TSCAN_FAST : TSCAN_SLOW);
				end
			end
			for (int i = 0; i < cnt; i++) begin
				res_m[i] = lvl[{ch[3:2], 2'(i)}];
				apb(OFS_RESULT_WORD | 8'(4 * i), 1'b0, 8'h00);
				check("scan result", rd[15:0], {res_m[i][9:0], 6'h00});
			end
			apb(OFS_CTRL_STATUS, 1'b0, 8'h00);
			check("scan flags", rd[7:5], 3'b111);
			wait_for(sh, 1'b1, n);
			wait_for(sh, 1'b0, n);
			apb(OFS_CTRL_STATUS, 1'b1, {4'b0101, k[0], ch[2:0]});
			n = muxq.size();
			repeat (300) @(posedge clock);
			check("scan stopped", muxq.size(), n);
			check("irq off", irq, 1'b0);
		end
		stop_test();
	end
endmodule : testbench
`default_nettype wire
